// >>> shared/psr_pkg.sv
// Constants, field positions and pin bundles for the signal routing block
package psr_pkg;

   // ==========================================================
   // Register map (I/O addresses)
   localparam logic [15:0] CORE_CTRL_ADDR  = 16'hf092;
   localparam logic [15:0] TIMER_CFG_ADDR  = 16'hf834;
   localparam logic [15:0] SERIAL_CFG_ADDR = 16'hf836;

   // ==========================================================
   // Reset values
   localparam logic [7:0] TIMER_CFG_RST  = 8'h00;
   localparam logic [7:0] SERIAL_CFG_RST = 8'h00;
   localparam logic       ADDR20_GATE_RST = 1'h1;
   localparam logic       CORE_RST_RST    = 1'h0;

   // ==========================================================
   // Timer routing fields
   localparam int TMR_CLOCK_DISABLE = 7;
   localparam int TMR_SW_GATE_EN    = 6;
   localparam int TMR_GATE2_SEL     = 5;
   localparam int TMR_CLOCK2_SEL    = 4;
   localparam int TMR_GATE1_SEL     = 3;
   localparam int TMR_CLOCK1_SEL    = 2;
   localparam int TMR_GATE0_SEL     = 1;
   localparam int TMR_CLOCK0_SEL    = 0;

   // ==========================================================
   // Serial routing fields
   localparam int SER_ASYNC1_MODEM = 7;
   localparam int SER_ASYNC0_MODEM = 6;
   localparam int SER_ASYNC1_BAUD  = 1;
   localparam int SER_ASYNC0_BAUD  = 0;
   localparam logic [7:0] SER_WRITABLE = 8'hc7;

   // ==========================================================
   // Core control port fields
   localparam int CCP_CORE_RESET  = 0;
   localparam int CCP_ADDR20_GATE = 1;
   localparam int ADDR_W          = 26;
   localparam int ADDR20_BIT      = 20;

   // ==========================================================
   // Pin and interrupt configuration fields
   localparam int PIN_REFRESH_SEL = 6;
   localparam int PIN_TIMER2_SEL  = 5;
   localparam int PIN_CS5_SEL     = 4;
   localparam int P3_POWER_DOWN_OUT_SEL  = 6;
   localparam int P3_LINE1_SEL    = 1;
   localparam int P3_LINE0_SEL    = 0;
   localparam int INT_IRQ8_SEL    = 6;
   localparam int INT_IRQ9_SEL    = 5;
   localparam int CS_SHARED_W     = 5;

   // Modem inputs of one async channel
   typedef struct packed {
      logic cts_n;
      logic dsr_n;
      logic dcd_n;
      logic ri_n;
   } psr_modem_t;

   // All package pin inputs that cross into the clock domain
   typedef struct packed {
      logic [1:0] cnt_clk_pin;
      logic [1:0] cnt_gate_pin;
      logic       c2_out_pin;
      logic       c2_clk_pin;
      logic       c2_gate_pin;
      logic       ext_serial_clk;
      psr_modem_t modem0;
      psr_modem_t modem1;
      logic [1:0] p3_low_pin;
   } psr_pin_in_t;

endpackage

// >>> rtl/psr_pin_sync.sv
// Three-stage pin input synchroniser with agreement filter
`timescale 1ns/10ps
`default_nettype none

module psr_pin_sync #(
   parameter int W = 1
) (
   input  wire logic         core_clk,
   input  wire logic         rst,
   input  wire logic [W-1:0] pin,
   output logic      [W-1:0] q
);

   logic [W-1:0] s1;
   logic [W-1:0] s2;
   logic [W-1:0] s3;

   // Shift chain; the first stage feeds only the second
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         s1 <= '0;
         s2 <= '0;
         s3 <= '0;
      end else begin
         s1 <= pin;
         s2 <= s1;
         s3 <= s2;
      end
   end

   // A bit changes only once stages two and three agree
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         q <= '0;
      end else begin
         for (int i = 0; i < W; i++) begin
            if (s2[i] == s3[i]) begin
               q[i] <= s3[i];
            end
         end
      end
   end

endmodule

`default_nettype wire

// >>> rtl/psr_routing.sv
// Peripheral signal routing: configuration registers and pin multiplexers
`timescale 1ns/10ps
`default_nettype none

module psr_routing (
   input  wire logic                        core_clk,
   input  wire logic                        rst,
   // Core I/O access
   input  wire logic [15:0]                 io_addr,
   input  wire logic                        io_wr,
   input  wire logic                        io_rd,
   input  wire logic [7:0]                  io_wdata,
   output logic      [7:0]                  io_rdata,
   // Configuration held by other units
   input  wire logic [7:0]                  pin_select_config,
   input  wire logic [7:0]                  port2_pin_config,
   input  wire logic [7:0]                  port3_pin_config,
   input  wire logic [7:0]                  interrupt_routing_config,
   // Package pin inputs
   input  wire psr_pkg::psr_pin_in_t        pin_in,
   // Timer unit
   input  wire logic                        prescaled_clock,
   input  wire logic [2:0]                  counter_out,
   output logic      [2:0]                  counter_clk,
   output logic      [2:0]                  counter_gate,
   // Async serial units
   input  wire psr_pkg::psr_modem_t         async0_modem_loop,
   input  wire psr_pkg::psr_modem_t         async1_modem_loop,
   input  wire logic                        internal_serial_clock,
   input  wire logic [3:0]                  async0_status,
   input  wire logic [3:0]                  async0_enable,
   input  wire logic [3:0]                  async1_status,
   input  wire logic [3:0]                  async1_enable,
   input  wire logic                        async0_modem_ctrl,
   input  wire logic                        async1_modem_ctrl,
   output psr_pkg::psr_modem_t              async0_modem_in,
   output psr_pkg::psr_modem_t              async1_modem_in,
   output logic      [1:0]                  async_baud_clk,
   output logic                             async0_irq,
   output logic                             async1_irq,
   output logic                             master_ir3,
   output logic                             master_ir4,
   output logic      [7:4]                  ext_irq_in,
   // Sync serial unit
   input  wire logic                        sync_rx_full,
   input  wire logic                        sync_tx_empty,
   input  wire logic [1:0]                  sync_serial_control1,
   output logic                             sync_serial_irq,
   // Core side
   input  wire logic [psr_pkg::ADDR_W-1:0]  bus_addr,
   input  wire logic                        bus_core_owned,
   output logic      [psr_pkg::ADDR_W-1:0]  mem_addr,
   output logic                             core_only_reset,
   output logic                             copro_request,
   output logic                             copro_busy_n,
   output logic                             copro_error_n,
   // Pin output sources
   input  wire logic                        chip_select6_n,
   input  wire logic                        chip_select5_n,
   input  wire logic [4:0]                  chip_select_low_n,
   input  wire logic                        refresh_n,
   input  wire logic                        dma_ack0_n,
   input  wire logic [4:0]                  port2_line,
   input  wire logic [1:0]                  port3_low_line,
   input  wire logic                        port3_line6,
   input  wire logic                        power_down_out,
   // Pin outputs
   output logic                             cs6_pin,
   output logic                             cs5_pin,
   output logic      [4:0]                  port2_pin,
   output logic                             port3_line6_pin,
   output logic      [1:0]                  p3_low_pin_o,
   output logic      [1:0]                  p3_low_pin_oe,
   output logic                             c2_out_pin_o,
   output logic                             c2_out_pin_oe
);

   // ==========================================================
   // Pin synchronisation
   psr_pkg::psr_pin_in_t pin_s;

   psr_pin_sync #(
      .W($bits(psr_pkg::psr_pin_in_t))
   ) u_sync (
      .core_clk (core_clk),
      .rst      (rst),
      .pin      (pin_in),
      .q        (pin_s)
   );

   // ==========================================================
   // Registers
   logic [7:0] timer_routing_config;
   logic [7:0] serial_routing_config;
   logic       addr20_gate;
   logic       core_reset_bit;
   logic       hit_ccp;
   logic       hit_tmr;
   logic       hit_ser;

   assign hit_ccp = (io_addr == psr_pkg::CORE_CTRL_ADDR);
   assign hit_tmr = (io_addr == psr_pkg::TIMER_CFG_ADDR);
   assign hit_ser = (io_addr == psr_pkg::SERIAL_CFG_ADDR);

   // Configuration register writes; reserved serial bits stay zero
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         timer_routing_config  <= psr_pkg::TIMER_CFG_RST;
         serial_routing_config <= psr_pkg::SERIAL_CFG_RST;
      end else if (io_wr) begin
         if (hit_tmr) begin
            timer_routing_config <= io_wdata;
         end
         if (hit_ser) begin
            serial_routing_config <= io_wdata & psr_pkg::SER_WRITABLE;
         end
      end
   end

   // reset values
   // Core control port; the reset pulse is clocked, so it never races the clock
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         addr20_gate     <= psr_pkg::ADDR20_GATE_RST;
         core_reset_bit  <= psr_pkg::CORE_RST_RST;
         core_only_reset <= 1'b0;
      end else begin
         core_only_reset <= 1'b0;
         if (io_wr && hit_ccp) begin
            addr20_gate    <= io_wdata[psr_pkg::CCP_ADDR20_GATE];
            core_reset_bit <= io_wdata[psr_pkg::CCP_CORE_RESET];
            core_only_reset <= io_wdata[psr_pkg::CCP_CORE_RESET] & ~core_reset_bit;
         end
      end
   end

   // Read data; unmapped addresses and reserved bits read zero
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         io_rdata <= 8'h00;
      end else if (io_rd) begin
         if (hit_ccp) begin
            io_rdata <= {6'h00, addr20_gate, core_reset_bit};
         end else if (hit_tmr) begin
            io_rdata <= timer_routing_config;
         end else if (hit_ser) begin
            io_rdata <= serial_routing_config;
         end else begin
            io_rdata <= 8'h00;
         end
      end
   end

   // ==========================================================
   // Timer routing
   logic [2:0] clk_pin;
   logic [2:0] gate_pin;
   logic [2:0] clk_sel;
   logic [2:0] gate_sel;
   logic       timer2_pins;
   logic [2:0] next_clk;
   logic [2:0] next_gate;

   // counter 2 pins only in timer mode
   assign timer2_pins = pin_select_config[psr_pkg::PIN_TIMER2_SEL];
   // counter 0/1 pins feed timer and irq inputs together
   assign clk_pin  = {pin_s.c2_clk_pin & timer2_pins, pin_s.cnt_clk_pin};
   assign gate_pin = {pin_s.c2_gate_pin & timer2_pins, pin_s.cnt_gate_pin};
   assign clk_sel  = {timer_routing_config[psr_pkg::TMR_CLOCK2_SEL],
                      timer_routing_config[psr_pkg::TMR_CLOCK1_SEL],
                      timer_routing_config[psr_pkg::TMR_CLOCK0_SEL]};
   assign gate_sel = {timer_routing_config[psr_pkg::TMR_GATE2_SEL],
                      timer_routing_config[psr_pkg::TMR_GATE1_SEL],
                      timer_routing_config[psr_pkg::TMR_GATE0_SEL]};

   // Clock and gate selection per counter
   always_comb begin
      for (int i = 0; i < 3; i++) begin
         next_clk[i] = clk_sel[i] ? clk_pin[i] : prescaled_clock;
         if (timer_routing_config[psr_pkg::TMR_CLOCK_DISABLE]) begin
            next_clk[i] = 1'b0;
         end
         if (timer_routing_config[psr_pkg::TMR_SW_GATE_EN]) begin
            next_gate[i] = gate_sel[i];
         end else begin
            next_gate[i] = gate_sel[i] ? gate_pin[i] : 1'b1;
         end
      end
   end

   // Registered timer inputs, one cycle behind the sources
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         counter_clk  <= 3'h0;
         counter_gate <= 3'h0;
      end else begin
         counter_clk  <= next_clk;
         counter_gate <= next_gate;
      end
   end

   // ==========================================================
   // Serial routing and interrupts
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         async0_modem_in <= '0;
         async1_modem_in <= '0;
         async_baud_clk  <= 2'h0;
         async0_irq      <= 1'b0;
         async1_irq      <= 1'b0;
         sync_serial_irq <= 1'b0;
      end else begin
         async0_modem_in <= serial_routing_config[psr_pkg::SER_ASYNC0_MODEM] ?
                            async0_modem_loop : pin_s.modem0;
         async1_modem_in <= serial_routing_config[psr_pkg::SER_ASYNC1_MODEM] ?
                            async1_modem_loop : pin_s.modem1;
         async_baud_clk[0] <= serial_routing_config[psr_pkg::SER_ASYNC0_BAUD] ?
                              internal_serial_clock : pin_s.ext_serial_clk;
         async_baud_clk[1] <= serial_routing_config[psr_pkg::SER_ASYNC1_BAUD] ?
                              internal_serial_clock : pin_s.ext_serial_clk;
         async0_irq <= |(async0_status & async0_enable);
         async1_irq <= |(async1_status & async1_enable);
         // control selects receive or transmit condition
         sync_serial_irq <= (sync_rx_full & sync_serial_control1[0]) |
                            (sync_tx_empty & sync_serial_control1[1]);
      end
   end

   // ==========================================================
   // Master irq 3/4 inputs and shared external irq pins
   logic irq8_mode;
   logic irq9_mode;

   assign irq8_mode = interrupt_routing_config[psr_pkg::INT_IRQ8_SEL];
   assign irq9_mode = interrupt_routing_config[psr_pkg::INT_IRQ9_SEL];

   // Pin input reaches the irq line only when the port bit also selects it
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         master_ir3 <= 1'b0;
         master_ir4 <= 1'b0;
         ext_irq_in <= 4'h0;
      end else begin
         if (!irq8_mode || async1_modem_ctrl) begin
            master_ir3 <= async1_irq;
         end else begin
            master_ir3 <= port3_pin_config[psr_pkg::P3_LINE1_SEL] & pin_s.p3_low_pin[1];
         end
         if (!irq9_mode || async0_modem_ctrl) begin
            master_ir4 <= async0_irq;
         end else begin
            master_ir4 <= port3_pin_config[psr_pkg::P3_LINE0_SEL] & pin_s.p3_low_pin[0];
         end
         // shared unmuxed pins, in order clk0, gate0, clk1, gate1
         ext_irq_in <= {pin_s.cnt_gate_pin[1], pin_s.cnt_clk_pin[1],
                        pin_s.cnt_gate_pin[0], pin_s.cnt_clk_pin[0]};
      end
   end

   // ==========================================================
   // Address line 20 gating
   logic [psr_pkg::ADDR_W-1:0] next_addr;

   // only core cycles lose line 20
   always_comb begin
      next_addr = bus_addr;
      if (bus_core_owned && !addr20_gate) begin
         next_addr[psr_pkg::ADDR20_BIT] = 1'b0;
      end
   end

   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         mem_addr <= '0;
      end else begin
         mem_addr <= next_addr;
      end
   end

   // ==========================================================
   // Pin multiplexers; each pin follows one config bit, except the port 3 low line enables, which also use the irq mode bits
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         cs6_pin         <= 1'b1;
         cs5_pin         <= 1'b1;
         port2_pin       <= 5'h00;
         port3_line6_pin <= 1'b0;
         p3_low_pin_o    <= 2'h0;
         p3_low_pin_oe   <= 2'h0;
         c2_out_pin_o    <= 1'b0;
         c2_out_pin_oe   <= 1'b0;
         copro_request   <= 1'b0;
         copro_busy_n    <= 1'b1;
         copro_error_n   <= 1'b1;
      end else begin
         cs6_pin <= pin_select_config[psr_pkg::PIN_REFRESH_SEL] ? refresh_n : chip_select6_n;
         // dma acknowledge or chip select 5
         cs5_pin <= pin_select_config[psr_pkg::PIN_CS5_SEL] ? chip_select5_n : dma_ack0_n;
         // port 2 line or chip select
         for (int i = 0; i < psr_pkg::CS_SHARED_W; i++) begin
            port2_pin[i] <= port2_pin_config[i] ? chip_select_low_n[i] : port2_line[i];
         end
         // port 3 line 6 or power-down
         port3_line6_pin <= port3_pin_config[psr_pkg::P3_POWER_DOWN_OUT_SEL] ?
                            power_down_out : port3_line6;
         // counter outputs drive only with port bit set and irq bit clear
         for (int i = 0; i < 2; i++) begin
            if (port3_pin_config[i]) begin
               p3_low_pin_o[i]  <= counter_out[i];
               p3_low_pin_oe[i] <= ~(i == 0 ? irq9_mode : irq8_mode);
            end else begin
               p3_low_pin_o[i]  <= port3_low_line[i];
               p3_low_pin_oe[i] <= 1'b1;
            end
         end
         // counter 2 group or coprocessor inputs
         c2_out_pin_o  <= counter_out[2];
         c2_out_pin_oe <= timer2_pins;
         copro_request <= ~timer2_pins & pin_s.c2_out_pin;
         copro_busy_n  <= timer2_pins | pin_s.c2_clk_pin;
         copro_error_n <= timer2_pins | pin_s.c2_gate_pin;
      end
   end

   // ==========================================================
   // Checks
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (rst);

   sequence ccp_set_s;
      io_wr && hit_ccp && io_wdata[psr_pkg::CCP_CORE_RESET] && !core_reset_bit;
   endsequence

   sequence ccp_reset_pulse_s;
      core_only_reset ##1 !core_only_reset;
   endsequence

   timer_clock_off_a: assert property (
      timer_routing_config[psr_pkg::TMR_CLOCK_DISABLE] |=> counter_clk == 3'h0)
      else $error("counter clock not held low while disabled");
   sw_gate_drive_a: assert property (
      timer_routing_config[psr_pkg::TMR_SW_GATE_EN] |=> counter_gate == $past(gate_sel))
      else $error("software gate does not follow select bits");
   gate_tied_high_a: assert property (
      !timer_routing_config[psr_pkg::TMR_SW_GATE_EN] && !gate_sel[0] |=> counter_gate[0])
      else $error("gate 0 not tied high");
   core_reset_pulse_a: assert property (
      ccp_set_s |=> ccp_reset_pulse_s)
      else $error("core reset pulse missing or too long");
   core_reset_hold_a: assert property (
      core_reset_bit && !(io_wr && hit_ccp) |=> !core_only_reset)
      else $error("core reset repeated without clearing");
   addr20_core_a: assert property (
      bus_core_owned && !addr20_gate |=> !mem_addr[psr_pkg::ADDR20_BIT])
      else $error("line 20 passed on core cycle");
   addr20_dma_a: assert property (
      !bus_core_owned |=> mem_addr == $past(bus_addr))
      else $error("non-core address altered");
   cs6_mux_a: assert property (
      pin_select_config[psr_pkg::PIN_REFRESH_SEL] |=> cs6_pin == $past(refresh_n))
      else $error("refresh strobe not on shared pin");
   async_irq_a: assert property (
      |(async0_status & async0_enable) |=> async0_irq)
      else $error("async 0 irq missing");
   timer2_oe_a: assert property (
      !pin_select_config[psr_pkg::PIN_TIMER2_SEL] |=> !c2_out_pin_oe)
      else $error("counter 2 drives coprocessor pin");

endmodule

`default_nettype wire

// >>> verif/psr_far_pins.sv
// Far-side model: the package pins that feed the routing block
`timescale 1ns/10ps
`default_nettype none

module psr_far_pins (
   input  wire logic                 core_clk,
   input  wire psr_pkg::psr_pin_in_t want,
   output var psr_pkg::psr_pin_in_t  pin_in
);
   // ==========================================================
   // Pin drive
   // Pins move on the falling edge, away from the sampling edge
   always @(negedge core_clk) pin_in <= want;
endmodule

`default_nettype wire

// >>> verif/peripheral_signal_routing_test.sv
// Self-checking bench for the peripheral signal routing block
`timescale 1ns/10ps
`default_nettype none

module peripheral_signal_routing_test;
   // ==========================================================
   // Signals named as the ports, so the instance binds them by name
   logic core_clk, rst, io_wr, io_rd, prescaled_clock, internal_serial_clock;
   logic [15:0] io_addr;
   logic [7:0] io_wdata, io_rdata, pin_select_config, port2_pin_config;
   logic [7:0] port3_pin_config, interrupt_routing_config;
   psr_pkg::psr_pin_in_t pin_in, want;
   psr_pkg::psr_modem_t async0_modem_loop, async1_modem_loop, async0_modem_in, async1_modem_in;
   logic [2:0] counter_out, counter_clk, counter_gate;
   logic [3:0] async0_status, async0_enable, async1_status, async1_enable;
   logic [7:4] ext_irq_in;
   logic [1:0] async_baud_clk, sync_serial_control1, port3_low_line, p3_low_pin_o, p3_low_pin_oe;
   logic async0_modem_ctrl, async1_modem_ctrl, async0_irq, async1_irq, master_ir3, master_ir4;
   logic sync_rx_full, sync_tx_empty, sync_serial_irq, bus_core_owned, core_only_reset;
   logic [25:0] bus_addr, mem_addr;
   logic copro_request, copro_busy_n, copro_error_n, chip_select6_n, chip_select5_n;
   logic refresh_n, dma_ack0_n, port3_line6, power_down_out, cs6_pin, cs5_pin;
   logic [4:0] chip_select_low_n, port2_line, port2_pin;
   logic port3_line6_pin, c2_out_pin_o, c2_out_pin_oe;
   int miscompares = 0;
   int tests_run = 0;

   psr_routing uut (.*);
   psr_far_pins far (.core_clk(core_clk), .want(want), .pin_in(pin_in));

   // ==========================================================
   // Clock and shared tasks
   initial begin
      core_clk = 1'b0;
      forever #2.5 core_clk = ~core_clk;
   end
   task automatic chk(input string n, input logic [25:0] e, input logic [25:0] g);
      tests_run++;
      if (g !== e) begin
         miscompares++;
         $display("CHECK FAILED %s expected %h seen %h", n, e, g);
      end
   endtask
   task automatic cyc(input int n);
      repeat (n) @(negedge core_clk);
   endtask
   // Strobe held across one rising edge, then effects allowed to land
   task automatic wr(input logic [15:0] a, input logic [7:0] d);
      @(negedge core_clk);
      {io_addr, io_wdata, io_wr} = {a, d, 1'b1};
      @(negedge core_clk);
      io_wr = 1'b0;
      cyc(3);
   endtask
   task automatic rd(input logic [15:0] a, input logic [7:0] e);
      @(negedge core_clk);
      {io_addr, io_rd} = {a, 1'b1};
      @(negedge core_clk);
      io_rd = 1'b0;
      chk("io_rdata", e, io_rdata);
   endtask
   // Counts reset pulse cycles, so the exact pulse cycle does not matter
   task automatic pulse(input logic [7:0] d, input logic [3:0] e);
      logic [3:0] n;
      n = 4'h0;
      @(negedge core_clk);
      {io_addr, io_wdata, io_wr} = {16'hf092, d, 1'b1};
      repeat (4) begin
         @(negedge core_clk);
         io_wr = 1'b0;
         n = n + core_only_reset;
      end
      chk("core reset pulses", e, n);
   endtask

   // ==========================================================
   // Scenarios
   task automatic t_regs;
      rd(16'hf092, 8'h02);
      rd(16'hf834, 8'h00);
      wr(16'hf836, 8'hff);
      rd(16'hf836, 8'hc7);
      rd(16'hf000, 8'h00);
   endtask
   task automatic t_timer;
      {prescaled_clock, counter_out} = 4'b1100;
      cyc(2);
      chk("clk prescaled_clock", 3'b111, counter_clk);
      chk("gate vcc", 3'b111, counter_gate);
      wr(16'hf834, 8'h80);
      chk("clk held", 3'b000, counter_clk);
      wr(16'hf834, 8'h40);
      chk("gate off", 3'b000, counter_gate);
      wr(16'hf834, 8'h6a);
      chk("gate on", 3'b111, counter_gate);
      {want.cnt_clk_pin, want.c2_clk_pin, want.cnt_gate_pin, want.c2_gate_pin} = 6'b111010;
      {pin_select_config, prescaled_clock} = {8'h20, 1'b0};
      wr(16'hf834, 8'h3f);
      cyc(6);
      chk("clk pin", 3'b111, counter_clk);
      chk("gate pin", 3'b001, counter_gate);
      chk("shared irq", 4'b0111, ext_irq_in);
      chk("timer2 grp", 5'b11011, {c2_out_pin_o, c2_out_pin_oe, copro_request, copro_busy_n, copro_error_n});
   endtask
   task automatic t_serial;
      {async0_modem_loop, async1_modem_loop, internal_serial_clock} = {8'h5a, 1'b1};
      {want.ext_serial_clk, want.modem0, want.modem1} = 9'h03c;
      // Earlier register test left internal sources selected
      wr(16'hf836, 8'h00);
      cyc(8);
      chk("modem pins", 8'h3c, {async0_modem_in, async1_modem_in});
      chk("baud ext", 2'b00, async_baud_clk);
      wr(16'hf836, 8'hc3);
      chk("modem loop", 8'h5a, {async0_modem_in, async1_modem_in});
      chk("baud int", 2'b11, async_baud_clk);
   endtask
   task automatic t_irq;
      {async0_status, async0_enable, async1_status, async1_enable} = 16'h4687;
      {sync_rx_full, sync_tx_empty, sync_serial_control1} = 4'b1001;
      cyc(3);
      chk("irq", 3'b101, {async0_irq, async1_irq, sync_serial_irq});
      {async1_enable, sync_serial_control1} = 6'b100010;
      cyc(3);
      chk("irq", 3'b110, {async0_irq, async1_irq, sync_serial_irq});
   endtask
   task automatic t_core;
      pulse(8'h03, 4'h1);
      rd(16'hf092, 8'h03);
      rd(16'hf834, 8'h3f);
      pulse(8'h03, 4'h0);
      pulse(8'h02, 4'h0);
      pulse(8'h03, 4'h1);
      {bus_addr, bus_core_owned} = {26'h3ffffff, 1'b1};
      wr(16'hf092, 8'h00);
      chk("a20 core", 26'h3efffff, mem_addr);
      bus_core_owned = 1'b0;
      cyc(3);
      chk("a20 dma", 26'h3ffffff, mem_addr);
   endtask
   task automatic t_pins;
      // Each pin pair carries opposite values, so a wrong mux leg shows
      {chip_select6_n, chip_select5_n, chip_select_low_n, port2_line} = 12'h555;
      {refresh_n, dma_ack0_n, port3_line6, power_down_out, port3_low_line} = 6'b100101;
      cyc(3);
      chk("muxes", 8'h2a, {cs6_pin, cs5_pin, port2_pin, port3_line6_pin});
      {pin_select_config, port2_pin_config, port3_pin_config} = 24'h501f40;
      cyc(3);
      chk("muxes", 8'hd5, {cs6_pin, cs5_pin, port2_pin, port3_line6_pin});
      chk("copro", 4'b1100, {copro_request, copro_busy_n, copro_error_n, c2_out_pin_oe});
      interrupt_routing_config = 8'h40;
      cyc(2);
      {port3_pin_config, want.p3_low_pin} = {8'h42, 2'b10};
      cyc(8);
      chk("ir pins", 5'b10111, {master_ir3, p3_low_pin_oe[1], master_ir4, p3_low_pin_o[0], p3_low_pin_oe[0]});
   endtask

   // ==========================================================
   // Main sequence, watchdog and verdict
   task automatic results;
      $display("checks %0d mismatches %0d", tests_run, miscompares);
      if (miscompares == 0 && tests_run > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask
   initial begin
      {io_wr, io_rd, prescaled_clock, internal_serial_clock, io_addr, io_wdata} = '0;
      {pin_select_config, port2_pin_config, port3_pin_config, interrupt_routing_config} = '0;
      {counter_out, async0_status, async0_enable, async1_status, async1_enable} = '0;
      {async0_modem_loop, async1_modem_loop, async0_modem_ctrl, async1_modem_ctrl} = '0;
      {sync_rx_full, sync_tx_empty, sync_serial_control1, bus_addr, bus_core_owned} = '0;
      {chip_select6_n, chip_select5_n, chip_select_low_n, refresh_n, dma_ack0_n} = '1;
      {port2_line, port3_low_line, port3_line6, power_down_out} = '0;
      {want, rst} = '1;
      cyc(6);
      rst = 1'b0;
      cyc(8);
      t_regs;
      t_timer;
      t_serial;
      t_irq;
      t_core;
      t_pins;
      results;
   end
   // About thirty times the expected run length
   initial begin
      #20000;
      miscompares++;
      results;
   end
endmodule

`default_nettype wire
